// ===== rtl/dfe_classify.sv
`timescale 1ns/1ns
module dfe_classify
    import dfe_pkg::*;
(
    input wire logic [7:0] vector,
    input wire logic is_irq,
    output dfe_class_e cls
);

    // unlisted vectors fall into the benign class so they never raise a double fault
    always_comb begin
        cls = CLS_BENIGN;
        if (!is_irq) begin
            if (vector == VEC_DE || vector == VEC_TS || vector == VEC_NP ||
                vector == VEC_SS || vector == VEC_GPROT) begin
                cls = CLS_CONTRIB;
            end else if (vector == VEC_PF) begin
                cls = CLS_PAGE;
            end
        end
    end

endmodule : dfe_classify

// ===== rtl/dfe_escalate.sv
`timescale 1ns/1ns
module dfe_escalate
    import dfe_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RSTN,
    input dfe_exc_s EXC,
    input wire logic CALL_DONE,
    input wire logic STATE_CORRUPT,
    input wire logic IN_NMI_HANDLER,
    input wire logic SYSTEM_MGMT_STATE,
    input wire logic COPRO_LEGACY,
    input wire logic NMI_PIN,
    input wire logic SYSTEM_MGMT_INTERRUPT_PIN,
    input wire logic INIT_PIN,
    input wire logic ADDRESS_BIT20_MASK_PIN,
    output dfe_deliv_s DELIVER,
    output logic SHUTDOWN_CYCLE,
    output logic HALTED,
    output logic [WAKE_W-1:0] WAKE_SRC,
    output logic ADDRESS_BIT20_MASK_SERVICE,
    output logic ADDRESS_BIT20_MASK_LEVEL
);

    function automatic logic has_err(input logic [7:0] vec);
        has_err = (vec == VEC_DBLF) || (vec == VEC_TS) || (vec == VEC_NP) ||
                  (vec == VEC_SS) || (vec == VEC_GPROT) || (vec == VEC_PF) ||
                  (vec == VEC_AC);
    endfunction : has_err

    function automatic logic escalates(input dfe_class_e first, input dfe_class_e second);
        escalates = ((first == CLS_CONTRIB || first == CLS_PAGE) && second == CLS_CONTRIB) ||
                    (first == CLS_PAGE && second == CLS_PAGE);
    endfunction : escalates

    function automatic dfe_deliv_s start_call(input logic [7:0] vec, input logic is_irq,
                                              input logic [31:0] err);
        dfe_deliv_s d;
        d.valid = 1'b1;
        d.vector = vec;
        d.abort = (vec == VEC_DBLF) || (vec == VEC_CSO);
        d.push_err = !is_irq && has_err(vec);
        d.err_code = d.push_err ? err : 32'h0000_0000;
        d.ip_defined = (vec != VEC_DBLF);
        start_call = d;
    endfunction : start_call

    // pin synchronisers: three stages, level accepted when stages two and three agree
    logic [PIN_W-1:0] pins;
    logic [PIN_W-1:0] s1_r, s2_r, s3_r, filt_r;
    logic [PIN_W-1:0] s1_nxt, s2_nxt, s3_nxt, filt_nxt;
    logic [PIN_W-1:0] rise;
    logic [PIN_W-1:0] chg;

    assign pins = {ADDRESS_BIT20_MASK_PIN, INIT_PIN, SYSTEM_MGMT_INTERRUPT_PIN, NMI_PIN};

    genvar gi;
    generate
        for (gi = 0; gi < PIN_W; gi++) begin : g_sync
            always_comb begin
                s1_nxt[gi] = pins[gi];
                s2_nxt[gi] = s1_r[gi];
                s3_nxt[gi] = s2_r[gi];
                filt_nxt[gi] = (s2_r[gi] == s3_r[gi]) ? s3_r[gi] : filt_r[gi];
                chg[gi] = (s2_r[gi] == s3_r[gi]) && (s3_r[gi] != filt_r[gi]);
                rise[gi] = chg[gi] && s3_r[gi];
            end
            always_ff @(posedge CLOCK or negedge RSTN) begin
                if (!RSTN) begin
                    s1_r[gi] <= 1'b0;
                    s2_r[gi] <= 1'b0;
                    s3_r[gi] <= 1'b0;
                    filt_r[gi] <= 1'b0;
                end else begin
                    s1_r[gi] <= s1_nxt[gi];
                    s2_r[gi] <= s2_nxt[gi];
                    s3_r[gi] <= s3_nxt[gi];
                    filt_r[gi] <= filt_nxt[gi];
                end
            end
        end
    endgenerate

    // incoming exception: remap retired vector, then classify
    logic [7:0] fix_vec;
    logic counts;
    dfe_class_e new_cls;

    always_comb begin
        fix_vec = EXC.vector;
        if (!EXC.is_irq && EXC.vector == VEC_CSO && !COPRO_LEGACY) begin
            fix_vec = VEC_GPROT;
        end
        // a fault raised during handler transfer counts; a prefetch-only one does not
        counts = EXC.valid && !EXC.prefetch;
    end

    dfe_classify u_classify (
        .vector(fix_vec),
        .is_irq(EXC.is_irq),
        .cls(new_cls)
    );

    // delivery state machine
    dfe_state_e state_r, state_nxt;
    dfe_deliv_s deliv_r, deliv_nxt;
    dfe_class_e cur_cls_r, cur_cls_nxt;
    dfe_exc_s pend_r, pend_nxt;
    dfe_class_e pend_cls_r, pend_cls_nxt;
    logic shut_cyc_r, shut_cyc_nxt;
    logic halted_r, halted_nxt;
    logic nmi_blk_r, nmi_blk_nxt;
    logic sysm_blk_r, sysm_blk_nxt;
    logic [WAKE_W-1:0] wake_r, wake_nxt;

    always_comb begin
        state_nxt = state_r;
        deliv_nxt = deliv_r;
        cur_cls_nxt = cur_cls_r;
        pend_nxt = pend_r;
        pend_cls_nxt = pend_cls_r;
        shut_cyc_nxt = 1'b0;
        nmi_blk_nxt = nmi_blk_r;
        sysm_blk_nxt = sysm_blk_r;
        wake_nxt = WAKE_RST;
        case (state_r)
            ST_IDLE: begin
                if (counts) begin
                    deliv_nxt = start_call(fix_vec, EXC.is_irq, EXC.err_code);
                    cur_cls_nxt = new_cls;
                    state_nxt = ST_CALL;
                end
            end
            ST_CALL: begin
                if (counts) begin
                    if (escalates(cur_cls_r, new_cls)) begin
                        pend_nxt = EXC_RST;
                        if (STATE_CORRUPT) begin
                            deliv_nxt = DELIV_RST;
                            state_nxt = ST_LOCKED;
                        end else begin
                            // error code forced to zero
                            deliv_nxt = start_call(VEC_DBLF, 1'b0, ERR_DBLF);
                            cur_cls_nxt = CLS_BENIGN;
                            state_nxt = ST_CALL_DBL;
                        end
                    end else begin
                        // single slot: a later serial exception replaces an earlier one
                        pend_nxt = EXC;
                        pend_nxt.vector = fix_vec;
                        pend_cls_nxt = new_cls;
                    end
                end else if (CALL_DONE) begin
                    if (pend_r.valid) begin
                        deliv_nxt = start_call(pend_r.vector, pend_r.is_irq,
                                               pend_r.err_code);
                        cur_cls_nxt = pend_cls_r;
                        pend_nxt = EXC_RST;
                    end else begin
                        deliv_nxt = DELIV_RST;
                        state_nxt = ST_IDLE;
                    end
                end
            end
            ST_CALL_DBL: begin
                if (counts) begin
                    deliv_nxt = DELIV_RST;
                    shut_cyc_nxt = 1'b1;
                    nmi_blk_nxt = IN_NMI_HANDLER;
                    sysm_blk_nxt = SYSTEM_MGMT_STATE;
                    state_nxt = ST_SHUTDOWN;
                end else if (CALL_DONE) begin
                    deliv_nxt = DELIV_RST;
                    state_nxt = ST_IDLE;
                end
            end
            ST_SHUTDOWN: begin
                // hardware reset is the only way out once either block bit is set
                if (!nmi_blk_r && !sysm_blk_r) begin
                    if (rise[PIN_SYSM]) begin
                        wake_nxt[WAKE_SYSM] = 1'b1;
                        state_nxt = ST_WAKE;
                    end else if (rise[PIN_NMI]) begin
                        wake_nxt[WAKE_NMI] = 1'b1;
                        state_nxt = ST_WAKE;
                    end else if (rise[PIN_INIT]) begin
                        wake_nxt[WAKE_INIT] = 1'b1;
                        state_nxt = ST_WAKE;
                    end
                end
            end
            ST_WAKE: begin
                nmi_blk_nxt = 1'b0;
                sysm_blk_nxt = 1'b0;
                state_nxt = ST_IDLE;
            end
            ST_LOCKED: begin
                state_nxt = ST_LOCKED;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
        halted_nxt = (state_nxt == ST_SHUTDOWN) || (state_nxt == ST_LOCKED);
    end

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            state_r <= STATE_RST;
            deliv_r <= DELIV_RST;
            cur_cls_r <= CLS_BENIGN;
            pend_r <= EXC_RST;
            pend_cls_r <= CLS_BENIGN;
            shut_cyc_r <= 1'b0;
            halted_r <= 1'b0;
            nmi_blk_r <= 1'b0;
            sysm_blk_r <= 1'b0;
            wake_r <= WAKE_RST;
        end else begin
            state_r <= state_nxt;
            deliv_r <= deliv_nxt;
            cur_cls_r <= cur_cls_nxt;
            pend_r <= pend_nxt;
            pend_cls_r <= pend_cls_nxt;
            shut_cyc_r <= shut_cyc_nxt;
            halted_r <= halted_nxt;
            nmi_blk_r <= nmi_blk_nxt;
            sysm_blk_r <= sysm_blk_nxt;
            wake_r <= wake_nxt;
        end
    end

    // mask-request changes are held while stopped and serviced once running again
    logic a20_pend_r, a20_pend_nxt;
    logic a20_srv_r, a20_srv_nxt;
    logic a20_lvl_r, a20_lvl_nxt;
    logic a20_run;

    always_comb begin
        a20_run = (state_r != ST_SHUTDOWN) && (state_r != ST_WAKE) && (state_r != ST_LOCKED);
        a20_srv_nxt = a20_pend_r && a20_run;
        // a new change in the service cycle wins over the clear
        a20_pend_nxt = chg[PIN_A20] || (a20_pend_r && !a20_srv_nxt);
        a20_lvl_nxt = a20_srv_nxt ? filt_r[PIN_A20] : a20_lvl_r;
    end

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            a20_pend_r <= 1'b0;
            a20_srv_r <= 1'b0;
            a20_lvl_r <= 1'b0;
        end else begin
            a20_pend_r <= a20_pend_nxt;
            a20_srv_r <= a20_srv_nxt;
            a20_lvl_r <= a20_lvl_nxt;
        end
    end

    assign DELIVER = deliv_r;
    assign SHUTDOWN_CYCLE = shut_cyc_r;
    assign HALTED = halted_r;
    assign WAKE_SRC = wake_r;
    assign ADDRESS_BIT20_MASK_SERVICE = a20_srv_r;
    assign ADDRESS_BIT20_MASK_LEVEL = a20_lvl_r;

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RSTN);

    a_class_page: assert property (
        EXC.valid && !EXC.is_irq && EXC.vector == VEC_PF |-> new_cls == CLS_PAGE)
        else $error("vector 14 not classed as page fault");

    a_dbl_on_pair: assert property (
        state_r == ST_CALL && counts && !STATE_CORRUPT &&
        cur_cls_r != CLS_BENIGN && new_cls == CLS_CONTRIB
        |=> state_r == ST_CALL_DBL && DELIVER.vector == VEC_DBLF)
        else $error("contributory pairing did not raise double fault");

    a_serial_benign: assert property (
        state_r == ST_CALL && counts && new_cls == CLS_BENIGN
        |=> state_r == ST_CALL && $stable(DELIVER) && pend_r.valid)
        else $error("benign second exception was not queued");

    a_dbl_abort: assert property (
        DELIVER.valid && DELIVER.vector == VEC_DBLF |-> DELIVER.abort && state_r == ST_CALL_DBL)
        else $error("double fault not delivered as abort");

    a_prefetch_skip: assert property (
        state_r == ST_CALL && EXC.valid && EXC.prefetch && !CALL_DONE
        |=> state_r == ST_CALL && $stable(DELIVER))
        else $error("prefetch fault affected delivery");

    a_shutdown_entry: assert property (
        state_r == ST_CALL_DBL && counts
        |=> state_r == ST_SHUTDOWN && HALTED && !DELIVER.valid)
        else $error("fault in double fault call did not shut down");

    a_shutdown_cycle: assert property (
        $rose(HALTED) && state_r == ST_SHUTDOWN |-> SHUTDOWN_CYCLE ##1 !SHUTDOWN_CYCLE)
        else $error("shutdown entry without single bus cycle mark");

    a_halt_held: assert property (
        state_r == ST_SHUTDOWN && WAKE_SRC == WAKE_RST |-> HALTED && !DELIVER.valid)
        else $error("shutdown did not hold the core halted");

    a_a20_held: assert property (
        state_r == ST_SHUTDOWN && a20_pend_r |=> !ADDRESS_BIT20_MASK_SERVICE && a20_pend_r)
        else $error("mask request serviced during shutdown");

    a_nmi_block: assert property (
        state_r == ST_SHUTDOWN && nmi_blk_r |=> state_r == ST_SHUTDOWN && WAKE_SRC == WAKE_RST)
        else $error("woke from shutdown entered in nmi handler");

    a_sysm_block: assert property (
        state_r == ST_SHUTDOWN && sysm_blk_r |=> state_r == ST_SHUTDOWN)
        else $error("woke from shutdown entered in system management state");

    a_dbl_err_zero: assert property (
        DELIVER.valid && DELIVER.vector == VEC_DBLF
        |-> DELIVER.push_err && DELIVER.err_code == ERR_DBLF)
        else $error("double fault error code not zero");

    a_dbl_ip_undef: assert property (
        DELIVER.valid |-> DELIVER.ip_defined == (DELIVER.vector != VEC_DBLF))
        else $error("saved pointer flag wrong for double fault");

    a_locked_stays: assert property (
        state_r == ST_LOCKED |=> state_r == ST_LOCKED && HALTED && !DELIVER.valid)
        else $error("locked state left without reset");

    a_no_vec9: assert property (
        !COPRO_LEGACY && EXC.valid && !EXC.prefetch && !EXC.is_irq &&
        EXC.vector == VEC_CSO && state_r == ST_IDLE |=> DELIVER.vector == VEC_GPROT)
        else $error("retired vector 9 not remapped to 13");

    a_vec9_abort: assert property (
        DELIVER.valid && DELIVER.vector == VEC_CSO
        |-> DELIVER.abort && !DELIVER.push_err && DELIVER.ip_defined)
        else $error("vector 9 delivery attributes wrong");

    a_dbl_drops: assert property (
        state_r == ST_CALL_DBL |-> !pend_r.valid)
        else $error("pending exception kept after escalation");

endmodule : dfe_escalate

// ===== rtl/dfe_pkg.sv
package dfe_pkg;

    typedef enum logic [1:0] {CLS_BENIGN, CLS_CONTRIB, CLS_PAGE} dfe_class_e;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CALL,
        ST_CALL_DBL,
        ST_SHUTDOWN,
        ST_WAKE,
        ST_LOCKED
    } dfe_state_e;

    localparam logic [7:0] VEC_DE = 8'h00;
    localparam logic [7:0] VEC_DBLF = 8'h08;
    localparam logic [7:0] VEC_CSO = 8'h09;
    localparam logic [7:0] VEC_TS = 8'h0a;
    localparam logic [7:0] VEC_NP = 8'h0b;
    localparam logic [7:0] VEC_SS = 8'h0c;
    localparam logic [7:0] VEC_GPROT = 8'h0d;
    localparam logic [7:0] VEC_PF = 8'h0e;
    localparam logic [7:0] VEC_AC = 8'h11;
    localparam logic [31:0] ERR_DBLF = 32'h0000_0000;

    localparam int PIN_NMI = 0;
    localparam int PIN_SYSM = 1;
    localparam int PIN_INIT = 2;
    localparam int PIN_A20 = 3;
    localparam int PIN_W = 4;

    localparam int WAKE_NMI = 0;
    localparam int WAKE_SYSM = 1;
    localparam int WAKE_INIT = 2;
    localparam int WAKE_W = 3;

    typedef struct packed {
        logic valid;
        logic [7:0] vector;
        logic is_irq;
        logic prefetch;
        logic [31:0] err_code;
    } dfe_exc_s;

    typedef struct packed {
        logic valid;
        logic [7:0] vector;
        logic abort;
        logic push_err;
        logic [31:0] err_code;
        logic ip_defined;
    } dfe_deliv_s;

    localparam dfe_deliv_s DELIV_RST = '0;
    localparam dfe_exc_s EXC_RST = '0;
    localparam dfe_state_e STATE_RST = ST_IDLE;
    localparam logic [PIN_W-1:0] PIN_RST = 4'h0;
    localparam logic [WAKE_W-1:0] WAKE_RST = 3'h0;

endpackage : dfe_pkg

// ===== verif/dfe_escalate_tb.sv
`timescale 1ns/1ns
module dfe_escalate_tb;
    import dfe_pkg::*;
    // flags: bit3 second is an interrupt, bit2 legacy vector 9, bit0 double fault expected
    typedef struct packed {
        logic [7:0] first;
        logic [7:0] second;
        logic [3:0] flags;
    } dfe_row_s;
    localparam dfe_deliv_s DBL_EXP = '{1'b1, VEC_DBLF, 1'b1, 1'b1, ERR_DBLF, 1'b0};

    logic clk, rstn, call_done, state_corrupt, in_nmi, sysm_mode, copro, a20;
    logic nmi, sysm_irq, init, shutdown_cycle, halted, a20_svc, a20_lvl, svc_halt, wake_seen;
    logic [1:0] resp_sel;
    logic [WAKE_W-1:0] wake_src;
    dfe_exc_s exc;
    dfe_deliv_s deliver;
    dfe_row_s rows [25];
    int fail_count, comparisons, cycles, svc_count;

    dfe_escalate uut (.CLOCK(clk), .RSTN(rstn), .EXC(exc), .CALL_DONE(call_done),
        .STATE_CORRUPT(state_corrupt), .IN_NMI_HANDLER(in_nmi), .SYSTEM_MGMT_STATE(sysm_mode),
        .COPRO_LEGACY(copro), .NMI_PIN(nmi), .SYSTEM_MGMT_INTERRUPT_PIN(sysm_irq),
        .INIT_PIN(init),
        .ADDRESS_BIT20_MASK_PIN(a20), .DELIVER(deliver), .SHUTDOWN_CYCLE(shutdown_cycle),
        .HALTED(halted), .WAKE_SRC(wake_src), .ADDRESS_BIT20_MASK_SERVICE(a20_svc),
        .ADDRESS_BIT20_MASK_LEVEL(a20_lvl));

    dfe_platform_model plat (.clock(clk), .rstn(rstn), .shutdown_cycle(shutdown_cycle),
        .resp_sel(resp_sel), .nmi_pin(nmi), .sysm_pin(sysm_irq), .init_pin(init));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic complete_run();
        $display("counts: %0d comparisons, %0d mismatches", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run

    // pulse flags are made sticky here so a one-cycle output is never missed
    // sampled on the falling edge, away from the edge that launches the outputs
    always @(negedge clk) begin
        cycles++;
        if (a20_svc === 1'b1) svc_count++;
        if (a20_svc === 1'b1 && halted === 1'b1) svc_halt = 1'b1;
        if (wake_src !== 3'h0) wake_seen = 1'b1;
        if (cycles == 5000) begin
            fail_count++;
            $display("ERROR t=%0t timeout got %h exp %h", $time, cycles, 0);
            complete_run();
        end
    end

    function automatic dfe_exc_s mk(input logic [7:0] v, input logic irq, input logic pf);
        mk = '{1'b1, v, irq, pf, 32'h0000_0000};
    endfunction : mk

    task automatic step(input dfe_exc_s e, input logic d);
        exc <= e;
        call_done <= d;
        @(posedge clk);
        #1;
    endtask : step

    task automatic chk(input logic [43:0] got, input logic [43:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic do_reset(input int n);
        rstn <= 1'b0;
        exc <= EXC_RST;
        call_done <= 1'b0;
        repeat (n) @(posedge clk);
        #1;
        chk(44'(deliver), 44'h0);
        chk(44'({halted, shutdown_cycle, wake_src, a20_svc}), 44'h0);
        rstn <= 1'b1;
        state_corrupt <= 1'b0;
        in_nmi <= 1'b0;
        sysm_mode <= 1'b0;
        @(posedge clk);
        #1;
    endtask : do_reset

    // page fault, contributory fault, then a fault while calling the double-fault handler
    task automatic enter_shutdown(input logic [1:0] sel);
        resp_sel <= sel;
        step(mk(VEC_PF, 1'b0, 1'b0), 1'b0);
        step(mk(VEC_GPROT, 1'b0, 1'b0), 1'b0);
        step(mk(VEC_DE, 1'b0, 1'b0), 1'b0);
        chk(44'({deliver.valid, halted, shutdown_cycle}), 44'h3);
        wake_seen = 1'b0;
        step(mk(VEC_GPROT, 1'b0, 1'b0), 1'b0);
        chk(44'({deliver.valid, halted, shutdown_cycle}), 44'h2);
    endtask : enter_shutdown

    initial begin
        rstn = 1'b0;
        exc = EXC_RST;
        call_done = 1'b0;
        state_corrupt = 1'b0;
        in_nmi = 1'b0;
        sysm_mode = 1'b0;
        copro = 1'b0;
        a20 = 1'b0;
        resp_sel = 2'h0;
        {fail_count, comparisons, cycles, svc_count} = '0;
        {svc_halt, wake_seen} = 2'h0;
        rows = '{20'h0d_00_1, 20'h00_0a_1, 20'h0a_0b_1, 20'h0b_0c_1, 20'h0c_0d_1,
            20'h0e_0d_1, 20'h0e_0e_1, 20'h0d_09_1, 20'h0d_0e_0, 20'h0e_01_0, 20'h0d_02_0,
            20'h0e_03_0, 20'h0d_04_0, 20'h0e_05_0, 20'h0d_06_0, 20'h0e_07_0, 20'h0d_10_0,
            20'h0e_11_0, 20'h0d_12_0, 20'h0e_13_0, 20'h0e_09_4, 20'h0e_0d_8, 20'h03_0d_0,
            20'h01_0e_0, 20'h11_00_0};
        do_reset(12);
        $display("test reset done");
        foreach (rows[i]) begin
            copro <= rows[i].flags[2];
            step(mk(rows[i].first, 1'b0, 1'b0), 1'b0);
            chk(44'(deliver.vector), 44'(rows[i].first));
            step(mk(rows[i].second, rows[i].flags[3], 1'b0), 1'b0);
            if (rows[i].flags[0]) chk(deliver, DBL_EXP);
            else chk(44'(deliver.vector), 44'(rows[i].first));
            step(EXC_RST, 1'b1);
            chk(44'({deliver.valid, deliver.vector}),
                rows[i].flags[0] ? 44'h0 : 44'({1'b1, rows[i].second}));
            step(EXC_RST, 1'b1);
            chk(44'(deliver.valid), 44'h0);
            step(EXC_RST, 1'b0);
        end
        $display("test class table done");
        copro <= 1'b1;
        step(mk(VEC_CSO, 1'b0, 1'b0), 1'b0);
        chk(deliver, dfe_deliv_s'{1'b1, VEC_CSO, 1'b1, 1'b0, 32'h0, 1'b1});
        step(EXC_RST, 1'b1);
        copro <= 1'b0;
        step(mk(VEC_CSO, 1'b0, 1'b0), 1'b0);
        chk(44'(deliver.vector), 44'(VEC_GPROT));
        step(EXC_RST, 1'b1);
        step(EXC_RST, 1'b0);
        $display("test vector 9 done");
        // a prefetch fault on top of a page fault must not escalate; a real one must
        step(mk(VEC_PF, 1'b0, 1'b0), 1'b0);
        step(mk(VEC_GPROT, 1'b0, 1'b1), 1'b0);
        chk(44'(deliver.vector), 44'(VEC_PF));
        step(mk(VEC_GPROT, 1'b0, 1'b0), 1'b0);
        chk(deliver, DBL_EXP);
        step(EXC_RST, 1'b1);
        step(EXC_RST, 1'b0);
        $display("test prefetch done");
        for (int s = 1; s < 4; s++) begin
            enter_shutdown(2'(s));
            if (s == 1) a20 <= 1'b1;
            for (int k = 0; k < 30 && wake_src === 3'h0; k++) step(EXC_RST, 1'b0);
            chk(44'({wake_src, halted}), 44'({3'(1 << (s - 1)), 1'b0}));
            step(EXC_RST, 1'b0);
            chk(44'(wake_src), 44'h0);
            if (s == 1) begin
                for (int k = 0; k < 10 && svc_count == 0; k++) step(EXC_RST, 1'b0);
                chk(44'({svc_halt, a20_lvl, 8'(svc_count)}), 44'h101);
            end
        end
        $display("test shutdown wake done");
        // shutdown inside the nmi handler, inside system management, and the locked state after a corrupt state
        for (int b = 0; b < 3; b++) begin
            in_nmi <= (b == 0);
            sysm_mode <= (b == 1);
            state_corrupt <= (b == 2);
            if (b < 2) enter_shutdown(2'(b + 1));
            else begin
                step(mk(VEC_PF, 1'b0, 1'b0), 1'b0);
                step(mk(VEC_GPROT, 1'b0, 1'b0), 1'b0);
                chk(44'({deliver.valid, halted, shutdown_cycle}), 44'h2);
                wake_seen = 1'b0;
            end
            repeat (30) step(EXC_RST, 1'b0);
            chk(44'({halted, wake_seen}), 44'h2);
            do_reset(3);
        end
        $display("test blocked shutdown done");
        complete_run();
    end
endmodule : dfe_escalate_tb

// ===== verif/dfe_platform_model.sv
`timescale 1ns/1ns
module dfe_platform_model (
    input wire logic clock,
    input wire logic rstn,
    input wire logic shutdown_cycle,
    input wire logic [1:0] resp_sel,
    output logic nmi_pin,
    output logic sysm_pin,
    output logic init_pin
);
    // answering the shutdown cycle is optional: resp_sel 0 stays silent, 1 nmi, 2 sysm, 3 init
    logic [4:0] cnt_r;
    logic [1:0] sel_r;
    logic act;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cnt_r <= 5'h00;
            sel_r <= 2'h0;
        end else if (shutdown_cycle && resp_sel != 2'h0) begin
            cnt_r <= 5'h01;
            sel_r <= resp_sel;
        end else if (cnt_r != 5'h00 && cnt_r != 5'h10) begin
            cnt_r <= cnt_r + 5'h01;
        end else begin
            cnt_r <= 5'h00;
        end
    end

    // a slow answer: the pin rises a few cycles late and drops again after a while
    assign act = cnt_r >= 5'h04;
    assign nmi_pin = act && sel_r == 2'h1;
    assign sysm_pin = act && sel_r == 2'h2;
    assign init_pin = act && sel_r == 2'h3;
endmodule : dfe_platform_model
